// ===== src/stack_frame_instruction_ext.sv
/*
 Execution of the frame-pointer extended operations, with an AHB-Lite slave
 for the frame pointer, control and status. Assumes the core presents each
 instruction word during the decode phase, and that data memory read data is
 valid combinationally in the clock in which o_mem_rd is high.
*/
// Local design decisions: the register offsets and the AHB-Lite slave port.
// What this block does
// - Add-and-return: two cycles, add literal, then reload PC from stack top.
// - Add-and-return word 1110 1000 11kk kkkk adds six bits to frame pointer.
// - Call via working register is the single word 0000 0000 0001 0100.
// - Call pushes PC plus 2, loads PC from working register and latches.
// - Call takes two cycles; second cycle is a no-operation.
// - Call never saves or restores working, status or bank select shadows.
// - Indexed-to-absolute source is frame pointer plus seven-bit offset.
// - Its destination is the 12-bit second word; written in last phase.
// - Computed addresses of both moves span the whole 4096-byte space.
// - A source on an indirect-access register moves 00h instead.
// - Indexed-to-indexed uses frame pointer plus separate seven-bit offsets.
// - Indexed destination on an indirect register makes the whole move a no-op.
// - Push literal writes at frame pointer, then decrements it, in one cycle.
// - Push opcode upper nibble is selectable, printed value by default.
`timescale 1ns/100ps
module stack_frame_instruction_ext
   import stack_frame_pkg::*;
(
   input  wire logic               i_clk_sys,
   input  wire logic               i_srst,
   input  wire logic               i_instr_valid,
   input  wire logic [15:0]        i_instr_word,
   input  wire logic [PC_W-1:0]    i_pc,
   input  wire logic [7:0]         i_working_register,
   input  wire logic [7:0]         i_pc_high_latch,
   input  wire logic [UPPER_W-1:0] i_pc_upper_latch,
   input  wire logic [PC_W-1:0]    i_return_stack_top,
   input  wire logic [7:0]         i_mem_rdata,
   output logic      [ADDR_W-1:0]  o_mem_addr,
   output logic      [7:0]         o_mem_wdata,
   output logic                    o_mem_rd,
   output logic                    o_mem_wr,
   output logic                    o_stack_push,
   output logic      [PC_W-1:0]    o_stack_push_data,
   output logic                    o_stack_pop,
   output logic                    o_pc_load,
   output logic      [PC_W-1:0]    o_pc_value,
   output logic                    o_busy,
   output logic      [1:0]         o_phase,
   input  wire logic               i_hsel,
   input  wire logic [31:0]        i_haddr,
   input  wire logic [1:0]         i_htrans,
   input  wire logic               i_hwrite,
   input  wire logic [2:0]         i_hsize,
   input  wire logic [31:0]        i_hwdata,
   input  wire logic               i_hready,
   output logic      [31:0]        o_hrdata,
   output logic                    o_hreadyout,
   output logic                    o_hresp
);

   logic [1:0]        phase;
   op_type            dec_op;

   state_type         state_reg,     state_next;
   op_type            op_reg,        op_next;
   op_type            last_op_reg,   last_op_next;
   logic [15:0]       word_reg,      word_next;
   logic [ADDR_W-1:0] fp_reg,        fp_next;
   logic [7:0]        data_reg,      data_next;
   logic              src_ind_reg,   src_ind_next;
   logic [ADDR_W-1:0] dest_reg,      dest_next;
   logic              dest_ok_reg,   dest_ok_next;
   logic [ADDR_W-1:0] mem_addr_reg,  mem_addr_next;
   logic [7:0]        wdata_reg,     wdata_next;
   logic              mem_rd_reg,    mem_rd_next;
   logic              mem_wr_reg,    mem_wr_next;
   logic              push_reg,      push_next;
   logic [PC_W-1:0]   push_data_reg, push_data_next;
   logic              pop_reg,       pop_next;
   logic              pc_load_reg,   pc_load_next;
   logic [PC_W-1:0]   pc_value_reg,  pc_value_next;
   logic              busy_reg,      busy_next;
   logic              core_fp_we;

   logic [1:0]        ctrl_reg,      ctrl_next;
   logic              wr_pend_reg,   wr_pend_next;
   logic [11:0]       wr_addr_reg,   wr_addr_next;
   logic [31:0]       hrdata_reg,    hrdata_next;
   logic              addr_take;
   logic              is_move;

   phase_gen u_phase_gen (
      .i_clk_sys (i_clk_sys),
      .i_srst    (i_srst),
      .o_phase   (phase)
   );

   ext_decode u_ext_decode (
      .i_word     (i_instr_word),
      .i_push_alt (ctrl_reg[CTRL_PUSH_ALT_BIT]),
      .o_op       (dec_op)
   );

   assign is_move = (op_reg == OP_MOVE_ABS) || (op_reg == OP_MOVE_IDX);

   // Instruction execution; strobes are one-clock pulses
   always_comb begin
      state_next     = state_reg;
      op_next        = op_reg;
      last_op_next   = last_op_reg;
      word_next      = word_reg;
      fp_next        = fp_reg;
      data_next      = data_reg;
      src_ind_next   = src_ind_reg;
      dest_next      = dest_reg;
      dest_ok_next   = dest_ok_reg;
      mem_addr_next  = mem_addr_reg;
      wdata_next     = wdata_reg;
      push_data_next = push_data_reg;
      pc_value_next  = pc_value_reg;
      mem_rd_next    = 1'b0;
      mem_wr_next    = 1'b0;
      push_next      = 1'b0;
      pop_next       = 1'b0;
      pc_load_next   = 1'b0;
      core_fp_we     = 1'b0;
      unique case (state_reg)
         ST_READY: begin
            if (phase == PH_DECODE && i_instr_valid && ctrl_reg[CTRL_ENABLE_BIT] && dec_op != OP_NONE) begin
               state_next   = ST_FIRST;
               op_next      = dec_op;
               last_op_next = dec_op;
               word_next    = i_instr_word;
            end
         end
         ST_FIRST: begin
            unique case (phase)
               PH_DECODE: begin
               end
               PH_FETCH: begin
                  if (op_reg == OP_PUSH) begin
                     mem_addr_next = fp_reg;
                     wdata_next    = word_reg[7:0];
                  end else if (is_move) begin
                     mem_addr_next = frame_addr(fp_reg, word_reg[6:0]);
                     src_ind_next  = is_indirect(frame_addr(fp_reg, word_reg[6:0]));
                  end
               end
               PH_PROCESS: begin
                  if (op_reg == OP_CALL_W) begin
                     push_next      = 1'b1;
                     push_data_next = i_pc + PC_STEP;
                  end else if (op_reg == OP_PUSH) begin
                     mem_wr_next = 1'b1;
                  end else if (is_move) begin
                     // Skipping the read avoids pointer side effects of an indirect access
                     mem_rd_next = !src_ind_reg;
                  end
               end
               PH_WRITE: begin
                  state_next = ST_READY;
                  if (op_reg == OP_ADD_RET) begin
                     fp_next    = fp_reg + {6'h00, word_reg[5:0]};
                     core_fp_we = 1'b1;
                     state_next = ST_SECOND;
                  end else if (op_reg == OP_PUSH) begin
                     fp_next    = fp_reg - 12'h001;
                     core_fp_we = 1'b1;
                  end else if (op_reg == OP_CALL_W) begin
                     // Only the program counter changes; no shadow copies are touched
                     pc_load_next  = 1'b1;
                     pc_value_next = {i_pc_upper_latch, i_pc_high_latch, i_working_register};
                     state_next    = ST_SECOND;
                  end else if (is_move) begin
                     data_next  = src_ind_reg ? ZERO_BYTE : i_mem_rdata;
                     state_next = ST_SECOND;
                  end
               end
            endcase
         end
         ST_SECOND: begin
            unique case (phase)
               PH_DECODE: begin
                  if (op_reg == OP_ADD_RET) begin
                     pc_load_next  = 1'b1;
                     pc_value_next = i_return_stack_top;
                     pop_next      = 1'b1;
                  end else if (op_reg == OP_MOVE_ABS) begin
                     dest_next    = i_instr_word[ADDR_W-1:0];
                     dest_ok_next = i_instr_valid && (i_instr_word & SECOND_MASK) == SECOND_VAL;
                  end else if (op_reg == OP_MOVE_IDX) begin
                     dest_next    = frame_addr(fp_reg, i_instr_word[6:0]);
                     dest_ok_next = i_instr_valid && (i_instr_word & SECOND_MASK) == SECOND_VAL &&
                                    !is_indirect(frame_addr(fp_reg, i_instr_word[6:0]));
                  end
               end
               PH_FETCH: begin
               end
               PH_PROCESS: begin
                  if (is_move && dest_ok_reg) begin
                     mem_addr_next = dest_reg;
                     wdata_next    = data_reg;
                     mem_wr_next   = 1'b1;
                  end
               end
               PH_WRITE: begin
                  state_next = ST_READY;
               end
            endcase
         end
      endcase
      // Instruction updates win over a bus write in the same clock
      if (wr_pend_reg && wr_addr_reg == FP_OFF && !core_fp_we) begin
         fp_next = i_hwdata[ADDR_W-1:0];
      end
      busy_next = (state_next != ST_READY);
   end

   // No status flag output exists; nothing here can alter one
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         state_reg     <= ST_READY;
         op_reg        <= OP_NONE;
         last_op_reg   <= OP_NONE;
         word_reg      <= 16'h0000;
         fp_reg        <= FP_RESET;
         data_reg      <= 8'h00;
         src_ind_reg   <= 1'b0;
         dest_reg      <= 12'h000;
         dest_ok_reg   <= 1'b0;
         mem_addr_reg  <= 12'h000;
         wdata_reg     <= 8'h00;
         mem_rd_reg    <= 1'b0;
         mem_wr_reg    <= 1'b0;
         push_reg      <= 1'b0;
         push_data_reg <= 21'h000000;
         pop_reg       <= 1'b0;
         pc_load_reg   <= 1'b0;
         pc_value_reg  <= 21'h000000;
         busy_reg      <= 1'b0;
      end else begin
         state_reg     <= state_next;
         op_reg        <= op_next;
         last_op_reg   <= last_op_next;
         word_reg      <= word_next;
         fp_reg        <= fp_next;
         data_reg      <= data_next;
         src_ind_reg   <= src_ind_next;
         dest_reg      <= dest_next;
         dest_ok_reg   <= dest_ok_next;
         mem_addr_reg  <= mem_addr_next;
         wdata_reg     <= wdata_next;
         mem_rd_reg    <= mem_rd_next;
         mem_wr_reg    <= mem_wr_next;
         push_reg      <= push_next;
         push_data_reg <= push_data_next;
         pop_reg       <= pop_next;
         pc_load_reg   <= pc_load_next;
         pc_value_reg  <= pc_value_next;
         busy_reg      <= busy_next;
      end
   end

   // Bus slave: zero wait states, read data registered in the address phase
   assign addr_take = i_hsel && i_htrans[1] && i_hready;

   always_comb begin
      ctrl_next    = ctrl_reg;
      wr_pend_next = addr_take && i_hwrite;
      wr_addr_next = addr_take ? i_haddr[11:0] : wr_addr_reg;
      hrdata_next  = 32'h00000000;
      if (wr_pend_reg && wr_addr_reg == CTRL_OFF) begin
         ctrl_next = i_hwdata[1:0];
      end
      if (addr_take && !i_hwrite) begin
         unique case (i_haddr[11:0])
            FP_OFF:     hrdata_next = {20'h00000, fp_reg};
            CTRL_OFF:   hrdata_next = {30'h00000000, ctrl_reg};
            STATUS_OFF: hrdata_next = {28'h0000000, last_op_reg, busy_reg};
            default:    hrdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         ctrl_reg    <= CTRL_RESET;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 12'h000;
         hrdata_reg  <= 32'h00000000;
      end else begin
         ctrl_reg    <= ctrl_next;
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         hrdata_reg  <= hrdata_next;
      end
   end

   assign o_mem_addr        = mem_addr_reg;
   assign o_mem_wdata       = wdata_reg;
   assign o_mem_rd          = mem_rd_reg;
   assign o_mem_wr          = mem_wr_reg;
   assign o_stack_push      = push_reg;
   assign o_stack_push_data = push_data_reg;
   assign o_stack_pop       = pop_reg;
   assign o_pc_load         = pc_load_reg;
   assign o_pc_value        = pc_value_reg;
   assign o_busy            = busy_reg;
   assign o_phase           = phase;
   assign o_hrdata          = hrdata_reg;
   assign o_hreadyout       = 1'b1;
   assign o_hresp           = 1'b0;

endmodule

// ===== shared/stack_frame_pkg.sv
/*
 Shared constants, types and helpers for the stack-frame instruction extension:
 opcode patterns, phase codes, register offsets and the indirect-register map.
 Assumes a 12-bit data space and a 21-bit program counter.
*/
package stack_frame_pkg;

   localparam int ADDR_W  = 12;
   localparam int PC_W    = 21;
   localparam int UPPER_W = 5;

   typedef enum logic [2:0] {
      OP_NONE, OP_ADD_RET, OP_CALL_W, OP_MOVE_ABS, OP_MOVE_IDX, OP_PUSH
   } op_type;

   typedef enum {ST_READY, ST_FIRST, ST_SECOND} state_type;

   localparam logic [1:0]  PH_DECODE  = 2'h0;
   localparam logic [1:0]  PH_FETCH   = 2'h1;
   localparam logic [1:0]  PH_PROCESS = 2'h2;
   localparam logic [1:0]  PH_WRITE   = 2'h3;

   localparam logic [15:0] ADD_RET_MASK  = 16'hFFC0;
   localparam logic [15:0] ADD_RET_VAL   = 16'hE8C0;
   localparam logic [15:0] CALL_W_WORD   = 16'h0014;
   localparam logic [15:0] MOVE_MASK     = 16'hFF80;
   localparam logic [15:0] MOVE_ABS_VAL  = 16'hEB00;
   localparam logic [15:0] MOVE_IDX_VAL  = 16'hEB80;
   localparam logic [15:0] PUSH_MASK     = 16'hFF00;
   localparam logic [15:0] PUSH_VAL      = 16'hFA00;
   localparam logic [15:0] PUSH_ALT_VAL  = 16'hEA00;
   localparam logic [15:0] SECOND_MASK   = 16'hF000;
   localparam logic [15:0] SECOND_VAL    = 16'hF000;

   localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;
   localparam logic [7:0]      ZERO_BYTE = 8'h00;

   localparam logic [11:0] FP_OFF     = 12'h000;
   localparam logic [11:0] CTRL_OFF   = 12'h004;
   localparam logic [11:0] STATUS_OFF = 12'h008;
   localparam int          CTRL_ENABLE_BIT   = 0;
   localparam int          CTRL_PUSH_ALT_BIT = 1;
   localparam logic [1:0]  CTRL_RESET        = 2'h1;
   localparam logic [ADDR_W-1:0] FP_RESET    = 12'h000;

   // Each pointer owns five consecutive indirect-access registers
   localparam logic [ADDR_W-1:0] INDIRECT_BASE0 = 12'hFEB;
   localparam logic [ADDR_W-1:0] INDIRECT_BASE1 = 12'hFE3;
   localparam logic [ADDR_W-1:0] INDIRECT_BASE2 = 12'hFDB;
   localparam logic [ADDR_W-1:0] INDIRECT_SPAN  = 12'h005;

   function automatic logic is_indirect(input logic [ADDR_W-1:0] addr);
      is_indirect = (addr - INDIRECT_BASE0 < INDIRECT_SPAN) ||
                    (addr - INDIRECT_BASE1 < INDIRECT_SPAN) ||
                    (addr - INDIRECT_BASE2 < INDIRECT_SPAN);
   endfunction

   // Wraps inside the data space, so every bank is reachable
   function automatic logic [ADDR_W-1:0] frame_addr(input logic [ADDR_W-1:0] fp,
                                                    input logic [6:0]        offset);
      frame_addr = fp + {5'h00, offset};
   endfunction

endpackage

// ===== src/phase_gen.sv
/*
 Four-phase sequencer: splits each instruction cycle into four clocks.
 Assumes a synchronous active-high reset.
*/
`timescale 1ns/100ps
module phase_gen
   import stack_frame_pkg::*;
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_srst,
   output logic      [1:0] o_phase
);

   logic [1:0] phase_reg;
   logic [1:0] phase_next;

   always_comb begin
      phase_next = phase_reg + 2'h1;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         phase_reg <= PH_DECODE;
      end else begin
         phase_reg <= phase_next;
      end
   end

   assign o_phase = phase_reg;

endmodule

// ===== src/ext_decode.sv
/*
 Opcode recogniser for the extended operations.
 Assumes the instruction word is stable while it is examined.
*/
`timescale 1ns/100ps
module ext_decode
   import stack_frame_pkg::*;
(
   input  wire logic [15:0] i_word,
   input  wire logic        i_push_alt,
   output op_type           o_op
);

   logic [15:0] push_val;

   always_comb begin
      push_val = i_push_alt ? PUSH_ALT_VAL : PUSH_VAL;
      o_op     = OP_NONE;
      if ((i_word & ADD_RET_MASK) == ADD_RET_VAL) begin
         o_op = OP_ADD_RET;
      end else if (i_word == CALL_W_WORD) begin
         o_op = OP_CALL_W;
      end else if ((i_word & MOVE_MASK) == MOVE_ABS_VAL) begin
         o_op = OP_MOVE_ABS;
      end else if ((i_word & MOVE_MASK) == MOVE_IDX_VAL) begin
         o_op = OP_MOVE_IDX;
      end else if ((i_word & PUSH_MASK) == push_val) begin
         o_op = OP_PUSH;
      end
   end

endmodule

// ===== sim/stack_frame_assertions.sv
/*
 Checker for the frame-pointer instruction block: phase order, strobe timing and values.
 Assumes it is bound to the block's top ports and that the enable bit stays set.
*/
`timescale 1ns/100ps
module stack_frame_assertions
   import stack_frame_pkg::*;
(
   input  wire logic               i_clk_sys,
   input  wire logic               i_srst,
   input  wire logic               i_instr_valid,
   input  wire logic [15:0]        i_instr_word,
   input  wire logic [PC_W-1:0]    i_pc,
   input  wire logic [7:0]         i_working_register,
   input  wire logic [7:0]         i_pc_high_latch,
   input  wire logic [UPPER_W-1:0] i_pc_upper_latch,
   input  wire logic [PC_W-1:0]    i_return_stack_top,
   input  wire logic [ADDR_W-1:0]  o_mem_addr,
   input  wire logic [7:0]         o_mem_wdata,
   input  wire logic               o_mem_rd,
   input  wire logic               o_mem_wr,
   input  wire logic               o_stack_push,
   input  wire logic [PC_W-1:0]    o_stack_push_data,
   input  wire logic               o_stack_pop,
   input  wire logic               o_pc_load,
   input  wire logic [PC_W-1:0]    o_pc_value,
   input  wire logic               o_busy,
   input  wire logic [1:0]         o_phase
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   logic            start;
   logic            is_push;
   logic            is_call;
   logic            is_ret;
   logic            is_abs;
   logic            second;
   logic [15:0]     word_q;
   logic [15:0]     next_q;
   logic [PC_W-1:0] pc_q;
   logic [PC_W-1:0] top_q;
   logic [PC_W-1:0] tgt_q;
   // Windows are short ranges opening two edges before the expected strobe and closing at most one edge after it
   assign start   = i_instr_valid && o_phase == PH_DECODE && !o_busy;
   assign is_push = start && (i_instr_word & PUSH_MASK) == PUSH_VAL;
   assign is_call = start && i_instr_word == CALL_W_WORD;
   assign is_ret  = start && (i_instr_word & ADD_RET_MASK) == ADD_RET_VAL;
   assign is_abs  = start && (i_instr_word & MOVE_MASK) == MOVE_ABS_VAL;
   assign second  = i_instr_valid && o_phase == PH_DECODE && (i_instr_word & SECOND_MASK) == SECOND_VAL;
   always_ff @(posedge i_clk_sys) begin
      if (start) begin
         word_q <= i_instr_word;
         pc_q   <= i_pc;
         top_q  <= i_return_stack_top;
         tgt_q  <= {i_pc_upper_latch, i_pc_high_latch, i_working_register};
      end
      if (i_instr_valid && o_phase == PH_DECODE) begin
         next_q <= i_instr_word;
      end
   end
   phase_step_a: assert property (
      !$past(i_srst) && !$past(i_srst, 2) |-> o_phase == $past(o_phase) + 2'h1)
      else $error("phase did not advance by one");
   push_write_a: assert property (
      is_push |-> ##[1:3] (o_mem_wr && o_mem_wdata == word_q[7:0]))
      else $error("push literal not written");
   call_push_a: assert property (
      is_call |-> ##[1:4] (o_stack_push && o_stack_push_data == pc_q + PC_STEP))
      else $error("call did not push next address");
   call_target_a: assert property (
      is_call |-> ##[2:5] (o_pc_load && o_pc_value == tgt_q))
      else $error("call target wrong or late");
   call_quiet_a: assert property (
      is_call |-> (!o_mem_wr && !o_stack_pop) [*8])
      else $error("call touched memory or popped");
   ret_load_a: assert property (
      is_ret |-> !o_pc_load [*3] ##[1:4] (o_pc_load && o_stack_pop && o_pc_value == top_q))
      else $error("return reload wrong or mistimed");
   src_direct_a: assert property (
      o_mem_rd |-> !is_indirect(o_mem_addr))
      else $error("read strobe on an indirect register");
   move_dest_a: assert property (
      is_abs ##4 second |-> ##[1:4] (o_mem_wr && o_mem_addr == next_q[11:0]))
      else $error("absolute move destination wrong");
endmodule
bind stack_frame_instruction_ext stack_frame_assertions stack_frame_assertions_inst (
   .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_instr_valid(i_instr_valid), .i_instr_word(i_instr_word),
   .i_pc(i_pc), .i_working_register(i_working_register), .i_pc_high_latch(i_pc_high_latch),
   .i_pc_upper_latch(i_pc_upper_latch), .i_return_stack_top(i_return_stack_top), .o_mem_addr(o_mem_addr),
   .o_mem_wdata(o_mem_wdata), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_stack_push(o_stack_push),
   .o_stack_push_data(o_stack_push_data), .o_stack_pop(o_stack_pop), .o_pc_load(o_pc_load),
   .o_pc_value(o_pc_value), .o_busy(o_busy), .o_phase(o_phase));

// ===== sim/core_side_model.sv
/*
 Core-side model: data memory, return stack and program counter.
 Assumes the block's strobes are one-clock pulses on the shared clock.
*/
`timescale 1ns/100ps
module core_side_model
   import stack_frame_pkg::*;
(
   input  wire logic              i_clk_sys,
   input  wire logic [ADDR_W-1:0] i_mem_addr,
   input  wire logic [7:0]        i_mem_wdata,
   input  wire logic              i_mem_rd,
   input  wire logic              i_mem_wr,
   input  wire logic              i_stack_push,
   input  wire logic [PC_W-1:0]   i_stack_push_data,
   input  wire logic              i_stack_pop,
   input  wire logic              i_pc_load,
   input  wire logic [PC_W-1:0]   i_pc_value,
   output logic      [7:0]        o_mem_rdata,
   output logic      [PC_W-1:0]   o_pc,
   output logic      [PC_W-1:0]   o_stack_top
);
   logic [7:0]      mem [4096];
   logic [PC_W-1:0] stack [8];
   logic [2:0]      sp;
   logic [7:0]      junk;
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'(i) ^ 8'h5A;
      end
      stack[0] = 21'h000000;
      sp = 3'h0;
      o_pc = 21'h000100;
      junk = 8'hA5;
   end
   // Read data is only good under the strobe; a moving pattern otherwise
   always_comb o_mem_rdata = i_mem_rd ? mem[i_mem_addr] : junk;
   assign o_stack_top = stack[sp];
   always @(posedge i_clk_sys) begin
      junk <= ~junk + 8'h01;
      if (i_mem_wr) begin
         mem[i_mem_addr] <= i_mem_wdata;
      end
      if (i_stack_push) begin
         stack[sp + 3'h1] <= i_stack_push_data;
         sp <= sp + 3'h1;
      end else if (i_stack_pop) begin
         sp <= sp - 3'h1;
      end
      if (i_pc_load) begin
         o_pc <= i_pc_value;
      end
   end
endmodule

// ===== sim/testbench.sv
/*
 Testbench: bus and instruction tasks, then operation scenarios with expected values.
 Assumes the core-side model and the bound checker.
*/
`timescale 1ns/100ps
module testbench;
   import stack_frame_pkg::*;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              vld = 1'b0;
   logic              hsel = 1'b0;
   logic              hwrite = 1'b0;
   logic [15:0]       word = 16'h0000;
   logic [1:0]        htrans = 2'h0;
   logic [31:0]       haddr = 32'h00000000;
   logic [31:0]       hwdata = 32'h00000000;
   logic [31:0]       hrdata, q;
   logic              hready, hresp, rd, wr, push, pop, load, busy;
   logic [ADDR_W-1:0] maddr;
   logic [7:0]        wdata, rdata;
   logic [PC_W-1:0]   pdata, pval, pc, top;
   logic [1:0]        phase;
   int                error_cnt = 0;
   int                num_checks = 0;
   always #25 clk = ~clk;
   stack_frame_instruction_ext stack_frame_instruction_ext_inst (
      .i_clk_sys(clk), .i_srst(rst), .i_instr_valid(vld), .i_instr_word(word), .i_pc(pc),
      .i_working_register(8'h06), .i_pc_high_latch(8'h10), .i_pc_upper_latch(5'h03),
      .i_return_stack_top(top), .i_mem_rdata(rdata), .o_mem_addr(maddr), .o_mem_wdata(wdata),
      .o_mem_rd(rd), .o_mem_wr(wr), .o_stack_push(push), .o_stack_push_data(pdata), .o_stack_pop(pop),
      .o_pc_load(load), .o_pc_value(pval), .o_busy(busy), .o_phase(phase), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp));
   core_side_model core_side_model_inst (
      .i_clk_sys(clk), .i_mem_addr(maddr), .i_mem_wdata(wdata), .i_mem_rd(rd), .i_mem_wr(wr),
      .i_stack_push(push), .i_stack_push_data(pdata), .i_stack_pop(pop), .i_pc_load(load),
      .i_pc_value(pval), .o_mem_rdata(rdata), .o_pc(pc), .o_stack_top(top));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // A wait that runs out ends the run as a failure
   task automatic give_up(input logic bad);
      if (bad) begin
         error_cnt++;
         stop_test;
      end
   endtask
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 16);
      give_up(hready !== 1'b1);
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      haddr <= {20'h00000, a};
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'b1;
      wait_ready;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready;
      q = hrdata;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000);
      check(q, exp);
      check({31'h00000000, hresp}, 32'h00000000);
   endtask
   task automatic mchk(input logic [11:0] a, input logic [7:0] exp);
      check({24'h000000, core_side_model_inst.mem[a]}, {24'h000000, exp});
   endtask
   // Word goes up on the edge before a decode phase and stays one clock
   task automatic issue(input logic [15:0] w);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (phase !== 2'h3 && n < 8);
      give_up(phase !== 2'h3);
      @(posedge clk);
      vld <= 1'b1;
      word <= w;
      @(posedge clk);
      vld <= 1'b0;
   endtask
   // Sets the frame pointer, issues one or two words, waits out two instruction cycles
   task automatic run(input logic [11:0] fp, input logic [15:0] w1, input logic [15:0] w2);
      int n;
      bus(1'b1, 12'h000, {20'h00000, fp});
      issue(w1);
      if (w2 != 16'h0000) begin
         issue(w2);
      end
      n = 0;
      repeat (8) @(negedge clk);
      while (busy !== 1'b0 && n < 16) begin
         @(negedge clk);
         n++;
      end
      give_up(busy !== 1'b0);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd_chk(12'h000, 32'h00000000);
      rd_chk(12'h004, 32'h00000001);
      rd_chk(12'h00C, 32'h00000000);
      run(12'h1EC, 16'hFA08, 16'h0000);
      mchk(12'h1EC, 8'h08);
      rd_chk(12'h000, 32'h000001EB);
      rd_chk(12'h008, 32'h0000000A);
      bus(1'b1, 12'h004, 32'h00000003);
      run(12'h1EC, 16'hEA55, 16'h0000);
      mchk(12'h1EC, 8'h55);
      bus(1'b1, 12'h004, 32'h00000001);
      run(12'h000, CALL_W_WORD, 16'h0000);
      check({11'h000, pc}, 32'h00031006);
      check({11'h000, top}, 32'h00000102);
      run(12'h3FF, 16'hE8E3, 16'h0000);
      rd_chk(12'h000, 32'h00000422);
      check({11'h000, pc}, 32'h00000102);
      // Move destinations avoid the PC low and stack-top bytes
      run(12'h080, 16'hEB05, 16'hF0A2);
      mchk(12'h0A2, 8'hDF);
      run(12'hFF0, 16'hEB7F, 16'hFF05);
      mchk(12'hF05, 8'h35);
      run(12'hFE0, 16'hEB0B, 16'hF0A3);
      mchk(12'h0A3, 8'h00);
      run(12'h080, 16'hEB85, 16'hF006);
      mchk(12'h086, 8'hDF);
      run(12'hFE0, 16'hEB85, 16'hF00B);
      mchk(12'hFEB, 8'hB1);
      stop_test;
   end
endmodule
